// ===== design/wdt_pkg.sv
// Summary of operation
// - tick comes from oscillator clock divided by 4096, 1024 or 128 via a mux
// - 8-bit up-counter, readable by software, never directly writable
// - any reset loads control register with zero: watchdog on, divide by 4096
// - watchdog off only while upper control nibble holds 1010b
// - writing one to control bit 1 clears the counter
// - writing one to control bit 0 clears the dividers of both timers
// - enabled watchdog and counter overflow out of bit 7 assert system reset
// - in stop mode, reset or external interrupt restarts oscillator and stabilization
// - stabilization ticks at divide 4096 after reset, selected divider after wake
// - stabilization ends when counter bit 4 sets; cpu clock is then released
package wdt_pkg;
	// register byte addresses on the bus
	localparam logic [7:0] ADDR_CONTROL = 8'hdc;
	localparam logic [7:0] ADDR_COUNT   = 8'hdd;
	localparam logic [7:0] ADDR_STATUS  = 8'he0;
	localparam logic [7:0] ADDR_MASK    = 8'he4;
	localparam logic [7:0] ADDR_MODE    = 8'he8;
	// control fields and values
	localparam logic [7:0] CONTROL_RESET   = 8'h00;
	localparam logic [3:0] DISABLE_CODE    = 4'ha;
	localparam int         BIT_CLR_COUNT   = 1;
	localparam int         BIT_CLR_DIV     = 0;
	localparam int         SEL_LSB         = 2;
	localparam int         KEY_LSB         = 4;
	localparam int         STAB_BIT        = 4;
	// clock select codes
	localparam logic [1:0] SEL_4096 = 2'h0;
	localparam logic [1:0] SEL_1024 = 2'h1;
	localparam logic [1:0] SEL_128  = 2'h2;
	// divider taps: a tick is the wrap of the low bits of a 12-bit prescaler
	localparam int DIV_W      = 12;
	localparam int TAP_4096   = 12;
	localparam int TAP_1024   = 10;
	localparam int TAP_128    = 7;
	// status bits
	localparam int ST_W       = 3;
	localparam int ST_OVF     = 0;
	localparam int ST_STAB    = 1;
	localparam int ST_BADSEL  = 2;
	// stabilization phases
	typedef enum logic [2:0] {
		WDT_RUN  = 3'b001,
		WDT_STOP = 3'b010,
		WDT_STAB = 3'b100
	} wdt_state_t;
	// bus request carrier
	typedef struct packed {
		logic       we;
		logic [7:0] adr;
		logic [7:0] dat;
	} wdt_req_t;
endpackage : wdt_pkg

// ===== design/wdt_top.sv
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module wdt_top (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// power management
	input  wire logic        stop_req_i,
	input  wire logic        ext_wake_i,
	// system effects
	output logic             sys_reset_o,
	output logic             cpu_clk_en_o,
	output logic             timer0_div_clr_o,
	output logic             irq_o
);
	logic [7:0]                       watchdog_timer_control;
	logic [7:0]                       watchdog_timer_count;
	logic [wdt_pkg::DIV_W-1:0]        prescale;
	logic [wdt_pkg::ST_W-1:0]         status;
	logic [wdt_pkg::ST_W-1:0]         mask;
	logic                             por_stab;
	wdt_pkg::wdt_state_t              state;
	wdt_pkg::wdt_req_t                req;
	logic                             wr_en;
	logic                             tick;
	logic                             wd_enabled;
	logic                             overflow;
	logic                             stab_done;
	logic [1:0]                       eff_sel;
	logic [wdt_pkg::ST_W-1:0]         events;

	assign req.we  = we_i;
	assign req.adr = adr_i;
	assign req.dat = dat_i[7:0];
	// a write lands once, in the cycle before ack rises
	assign wr_en = cyc_i && stb_i && req.we && sel_i[0] && !ack_o;

	// after a power-on style reset the stabilization runs at 4096 whatever is set
	assign eff_sel = (state == wdt_pkg::WDT_STAB && por_stab) ? wdt_pkg::SEL_4096
		: watchdog_timer_control[wdt_pkg::SEL_LSB +: 2];

	// divider taps: tick when the selected low bits of the prescaler are all ones
	always_comb
	begin
		case (eff_sel)
			wdt_pkg::SEL_4096: tick = &prescale[wdt_pkg::TAP_4096-1:0];
			wdt_pkg::SEL_1024: tick = &prescale[wdt_pkg::TAP_1024-1:0];
			wdt_pkg::SEL_128:  tick = &prescale[wdt_pkg::TAP_128-1:0];
			default:           tick = 1'b0;   // invalid select: counter holds
		endcase
	end

	// stop mode freezes the oscillator, hence both counter and divider
	assign wd_enabled = watchdog_timer_control[7:wdt_pkg::KEY_LSB] != wdt_pkg::DISABLE_CODE;
	assign overflow   = tick && (&watchdog_timer_count) && state != wdt_pkg::WDT_STOP;
	assign stab_done  = state == wdt_pkg::WDT_STAB && watchdog_timer_count[wdt_pkg::STAB_BIT];

	// prescaler, shared clear with timer 0
	always_ff @(posedge clk_i)
	begin
		if (rst_i || (wr_en && req.adr == wdt_pkg::ADDR_CONTROL && req.dat[wdt_pkg::BIT_CLR_DIV]))
			prescale <= '0;
		else if (state != wdt_pkg::WDT_STOP)
			prescale <= prescale + 1'b1;
	end

	// control register; clear bits are strobes and do not stay set
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			watchdog_timer_control <= wdt_pkg::CONTROL_RESET;
		else if (wr_en && req.adr == wdt_pkg::ADDR_CONTROL)
			watchdog_timer_control <= {req.dat[7:2], 2'b00};
	end

	// counter: read only, clears on strobe, reset or wake from stop
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			watchdog_timer_count <= '0;
		else if (wr_en && req.adr == wdt_pkg::ADDR_CONTROL && req.dat[wdt_pkg::BIT_CLR_COUNT])
			watchdog_timer_count <= '0;
		else if (state == wdt_pkg::WDT_STOP && ext_wake_i)
			watchdog_timer_count <= '0;   // restart count from oscillator start
		else if (tick && state != wdt_pkg::WDT_STOP)
			watchdog_timer_count <= watchdog_timer_count + 1'b1;
	end

	// stop and stabilization sequencer; reset itself starts a stabilization
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state    <= wdt_pkg::WDT_STAB;
			por_stab <= 1'b1;
		end
		else
		begin
			case (state)
				wdt_pkg::WDT_RUN:
				begin
					if (stop_req_i)
						state <= wdt_pkg::WDT_STOP;
				end
				wdt_pkg::WDT_STOP:
				begin
					if (ext_wake_i)
					begin
						state    <= wdt_pkg::WDT_STAB;
						por_stab <= 1'b0;
					end
				end
				wdt_pkg::WDT_STAB:
				begin
					if (stab_done)
						state <= wdt_pkg::WDT_RUN;
				end
				default: state <= wdt_pkg::WDT_RUN;
			endcase
		end
	end

	// cpu clock gate: open only while running
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cpu_clk_en_o <= 1'b0;
		else
			cpu_clk_en_o <= (state == wdt_pkg::WDT_RUN && !stop_req_i) || stab_done;
	end

	// watchdog reset pulse; software keeping the counter low is what avoids it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sys_reset_o <= 1'b0;
		else
			sys_reset_o <= overflow && wd_enabled;
	end

	// divider clear mirrored to timer 0 as a one-cycle pulse
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			timer0_div_clr_o <= 1'b0;
		else
			timer0_div_clr_o <= wr_en && req.adr == wdt_pkg::ADDR_CONTROL
				&& req.dat[wdt_pkg::BIT_CLR_DIV];
	end

	// sticky status: set wins over write-one-to-clear
	assign events[wdt_pkg::ST_OVF]    = overflow;
	assign events[wdt_pkg::ST_STAB]   = stab_done;
	assign events[wdt_pkg::ST_BADSEL] = wr_en && req.adr == wdt_pkg::ADDR_CONTROL
		&& req.dat[wdt_pkg::SEL_LSB +: 2] == 2'h3;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status <= '0;
		else if (wr_en && req.adr == wdt_pkg::ADDR_STATUS)
			status <= (status & ~req.dat[wdt_pkg::ST_W-1:0]) | events;
		else
			status <= status | events;
	end

	// interrupt mask
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mask <= '0;
		else if (wr_en && req.adr == wdt_pkg::ADDR_MASK)
			mask <= req.dat[wdt_pkg::ST_W-1:0];
	end

	// level interrupt, registered so it follows status by one cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(status & mask);
	end

	// bus answer: one wait state, ack for one cycle, unmapped reads zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end
		else
		begin
			ack_o <= cyc_i && stb_i && !ack_o;
			case (req.adr)
				wdt_pkg::ADDR_CONTROL: dat_o <= {24'h0, watchdog_timer_control};
				wdt_pkg::ADDR_COUNT:   dat_o <= {24'h0, watchdog_timer_count};
				wdt_pkg::ADDR_STATUS:  dat_o <= {29'h0, status};
				wdt_pkg::ADDR_MASK:    dat_o <= {29'h0, mask};
				wdt_pkg::ADDR_MODE:    dat_o <= {29'h0, state};
				default:               dat_o <= '0;
			endcase
		end
	end
endmodule : wdt_top

// ===== dv/wdt_asserts.sv
`timescale 1ns/1ps
module wdt_asserts (
	// bus side
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	// system effects
	input wire logic        sys_reset_o,
	input wire logic        cpu_clk_en_o,
	input wire logic        timer0_div_clr_o,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// a request is taken only while no answer is pending
	sequence s_take;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_div_wr;
		s_take ##0 (we_i && sel_i[0] && dat_i[0] && adr_i == wdt_pkg::ADDR_CONTROL);
	endsequence
	chk_ack_next: assert property (s_take |=> ack_o) else $error("ack late");
	chk_ack_once: assert property (ack_o |=> !ack_o) else $error("ack held");
	chk_read_width: assert property (ack_o |-> dat_o[31:8] == 24'h0)
		else $error("upper bits set");
	chk_unmapped_zero: assert property (ack_o && !$past(we_i) && !($past(adr_i) inside
		{8'hdc, 8'hdd, 8'he0, 8'he4, 8'he8}) |-> dat_o == 32'h0) else $error("hole read");
	chk_div_clear: assert property (s_div_wr |=> timer0_div_clr_o) else $error("no clr");
	chk_div_cause: assert property (timer0_div_clr_o |-> $past(cyc_i && we_i && dat_i[0]
		&& adr_i == wdt_pkg::ADDR_CONTROL)) else $error("stray clr");
	chk_reset_pulse: assert property (sys_reset_o |=> !sys_reset_o)
		else $error("reset held");
	// reset must quiet the gate and the reset request, so this one ignores the disable
	chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !cpu_clk_en_o
		&& !sys_reset_o && !irq_o) else $error("outputs not quiet");
endmodule : wdt_asserts
bind wdt_top wdt_asserts u_chk (.*);

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
	logic        clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic        cyc_i = 1'h0;
	logic        stb_i = 1'h0;
	logic        we_i  = 1'h0;
	logic        stop_req_i = 1'h0;
	logic        ext_wake_i = 1'h0;
	logic [7:0]  adr_i = 8'h0;
	logic [3:0]  sel_i = 4'h1;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o, rd;
	logic        ack_o, sys_reset_o, cpu_clk_en_o, timer0_div_clr_o, irq_o;
	logic [7:0]  ctl;
	int          mismatches = 0, total_checks = 0, n, t0, cyc_n = 0;
	int unsigned seed = 32'h1050;
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) cyc_n++;
	wdt_top u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
		.ack_o, .stop_req_i, .ext_wake_i, .sys_reset_o, .cpu_clk_en_o, .timer0_div_clr_o, .irq_o);
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : xs
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	// one classic cycle; read data is taken at the ack edge, then an idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		n = 0;
		do begin @(posedge clk_i); n++; end while (ack_o !== 1'h1 && n < 20);
		rd = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
		if (n >= 20) begin mismatches++; end_of_test(); end
	endtask : wb
	// bounded wait on the cpu gate (k=0) or the reset request (k=1)
	task automatic wait_hi(input int k, input int lim);
		t0 = cyc_n;
		while ((k ? sys_reset_o : cpu_clk_en_o) !== 1'h1 && cyc_n - t0 < lim) @(posedge clk_i);
		if (cyc_n - t0 >= lim) begin mismatches++; end_of_test(); end
	endtask : wait_hi
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		wb(0, wdt_pkg::ADDR_CONTROL, 8'h0);
		check(rd, 32'(wdt_pkg::CONTROL_RESET));
		wb(1, wdt_pkg::ADDR_COUNT, xs());
		wb(0, wdt_pkg::ADDR_COUNT, 8'h0);
		check(rd, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			ctl = 8'h10 | (xs() & 8'h0f);
			wb(1, ctl, xs());
			wb(0, ctl, 8'h0);
			check(rd, 32'h0);
		end
		wait_hi(0, 70000);
		check(32'((cyc_n - 3 + 2048) / 4096), 32'h10);
		wb(0, wdt_pkg::ADDR_COUNT, 8'h0);
		check(rd, 32'h10);
		wb(1, wdt_pkg::ADDR_MASK, 8'h02);
		check(32'(irq_o), 32'h1);
		wb(1, wdt_pkg::ADDR_STATUS, 8'h02);
		check(32'(irq_o), 32'h0);
		// walk every select code under the disable key; strobes read back zero
		for (int i = 0; i < 4; i++)
		begin
			ctl = {wdt_pkg::DISABLE_CODE, 2'(i), 2'h3};
			wb(1, wdt_pkg::ADDR_CONTROL, ctl);
			wb(0, wdt_pkg::ADDR_CONTROL, 8'h0);
			check(rd, 32'(ctl & 8'hfc));
		end
		wb(0, wdt_pkg::ADDR_STATUS, 8'h0);
		check(32'(rd[wdt_pkg::ST_BADSEL]), 32'h1);
		wb(1, wdt_pkg::ADDR_CONTROL, 8'hab);
		wb(0, wdt_pkg::ADDR_COUNT, 8'h0);
		check(rd, 32'h0);
		stop_req_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		stop_req_i <= 1'h0;
		wb(0, wdt_pkg::ADDR_MODE, 8'h0);
		check(rd, 32'h2);
		check(32'(cpu_clk_en_o), 32'h0);
		ext_wake_i <= 1'h1;
		@(posedge clk_i);
		ext_wake_i <= 1'h0;
		wait_hi(0, 3000);
		check(32'((cyc_n - t0 + 64) / 128), 32'h10);
		// key other than the disable code arms the watchdog; no clear follows
		wb(1, wdt_pkg::ADDR_CONTROL, 8'h0b);
		wait_hi(1, 34000);
		check(32'((cyc_n - t0 + 64) / 128), 32'h100);
		wb(0, wdt_pkg::ADDR_STATUS, 8'h0);
		check(32'(rd[wdt_pkg::ST_OVF]), 32'h1);
		end_of_test();
	end
endmodule : tb
